// [hw/drof_map.vh]
`ifndef DROF_MAP_VH
`define DROF_MAP_VH
// Clock rate and derived timing
`define DROF_CLK_KHZ         250000
`define DROF_FULL_LOAD_MS    200
`define DROF_DIR_PULSE_MS    100
// Output function selector codes
`define DROF_SEL_W           5
`define DROF_FN_OFF          5'h00
`define DROF_FN_BRAKE        5'h01
`define DROF_FN_INV_LIM1     5'h02
`define DROF_FN_INV_LIM2     5'h03
`define DROF_FN_STANDSTILL   5'h04
`define DROF_FN_REGEN_STBY   5'h05
`define DROF_FN_SUSP_WEAR    5'h06
`define DROF_FN_DIR_PULSE    5'h07
`define DROF_FN_FULL_LOAD    5'h08
`define DROF_FN_SLOWDOWN     5'h09
`define DROF_FN_TQ_INFO      5'h0A
`define DROF_FN_INV_TQ_INFO  5'h0B
`define DROF_FN_BRAKE_INFO   5'h0C
`define DROF_FN_REGEN_EN     5'h0D
`define DROF_FN_STUTTER      5'h0E
`define DROF_FN_MOT_SHORT    5'h0F
`define DROF_FN_MAINS_DISC   5'h10
`define DROF_FN_LAST         5'h10
// Register word addresses
`define DROF_ADDR_W          4
`define DROF_REG_SEL0        4'h0
`define DROF_REG_SEL1        4'h1
`define DROF_REG_SEL2        4'h2
`define DROF_REG_SEL3        4'h3
`define DROF_REG_LIMIT1      4'h4
`define DROF_REG_LIMIT2      4'h5
`define DROF_REG_CURR_THR    4'h6
`define DROF_REG_FLUX_TIME   4'h7
`define DROF_REG_BRAKE_CFG   4'h8
`define DROF_REG_LIFE_LOAD   4'h9
`define DROF_REG_LIFE_WARN   4'hA
`define DROF_REG_LIFE_CTRL   4'hB
`define DROF_REG_STATUS      4'hC
`define DROF_REG_LIFE_CNT    4'hD
// Field positions
`define DROF_LIFE_CTRL_RELOAD 0
`define DROF_BRK_MASK_LO     0
`define DROF_BRK_POL_LO      4
`define DROF_ST_RELAY_LO     0
`define DROF_ST_EVAC_LO      4
`define DROF_ST_WARN         6
`define DROF_ST_STILL        7
// Reset values
`define DROF_RST_SEL         5'h00
`define DROF_RST_SPEED       16'h0000
`define DROF_RST_FLUX        32'h0000_0100
`define DROF_RST_BRK         8'h01
`define DROF_RST_LIFE        32'h0000_0000
// Evacuation sequence states
`define DROF_EV_IDLE         2'h0
`define DROF_EV_WAIT_STILL   2'h1
`define DROF_EV_RESTART      2'h2
`define DROF_EV_WAIT_LINE    2'h3
`endif

// [hw/drof_hold_timer.v]
`timescale 1ns/1ps
`default_nettype none
// Reports a condition that has held for limit cycles without a break
module drof_hold_timer #(
  parameter W = 32
) (
  input  wire         clk,
  input  wire         sys_rst,
  input  wire         run,
  input  wire [W-1:0] limit,
  output reg          done
);
  reg [W-1:0] cnt_q;
  always @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= {W{1'b0}};
      done  <= 1'b0;
    end else if (!run) begin
      cnt_q <= {W{1'b0}};
      done  <= 1'b0;
    end else begin
      if (cnt_q != limit) begin
        cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      end
      done <= (cnt_q == limit);
    end
  end
endmodule
`default_nettype wire

// [hw/drof_life_counter.v]
`timescale 1ns/1ps
`default_nettype none
// Remaining-life down-counter with a latched warning
module drof_life_counter #(
  parameter W = 32
) (
  input  wire         clk,
  input  wire         sys_rst,
  input  wire         reload,
  input  wire [W-1:0] load_val,
  input  wire         tick,
  input  wire [W-1:0] warn_thr,
  output reg  [W-1:0] count,
  output reg          warn
);
  always @(posedge clk) begin
    if (sys_rst) begin
      count <= {W{1'b0}};
      warn  <= 1'b0;
    end else if (reload) begin
      count <= load_val;
      warn  <= 1'b0;                                   // [RL10]
    end else begin
      if (tick && count != {W{1'b0}}) begin
        count <= count - {{(W-1){1'b0}}, 1'b1};
      end
      if (count <= warn_thr) begin
        warn <= 1'b1;                                  // [RL9]
      end
    end
  end
endmodule
`default_nettype wire

// [hw/drof_output_logic.v]
`timescale 1ns/1ps
`default_nettype none
`include "drof_map.vh"
// What this block does
// RL1 - Each relay output has a selector; it follows only the selected condition.
// RL2 - An output with no function selected stays open.
// RL3 - Brake release closes after flux build-up time; contactor then opens brake.
// RL4 - Inverted limit one closes while speed exceeds limit one.
// RL5 - Inverted limit two closes while speed exceeds limit two.
// RL6 - Standstill opens at trip start once actual speed is above zero.
// RL7 - Standstill closes when speed is zero and mode contactor output is zero.
// RL8 - Regen standby output puts the feedback unit into standby while idle.
// RL9 - Suspension wear closes when remaining life reaches about one year.
// RL10 - Suspension wear stays closed until the life counter is reloaded.
// RL11 - One pulse on each travel direction change, for an external counter.
// RL12 - Full load closes when current stays above threshold 200 ms at constant speed.
// RL13 - Closed loop slowdown: decelerating from speed three, actual below limit one.
// RL14 - Open loop slowdown: decelerating from speed three, nominal below limit one.
// RL15 - Slowdown output drops as soon as the relevant speed reaches zero.
// RL16 - Torque-off status closes while the power stage is not blocked.
// RL17 - Inverted torque-off status closes while the power stage is blocked.
// RL18 - Brake status closes when monitor inputs show brakes open during travel.
// RL19 - Regen enable closes with controller enable, speed and direction all present.
// RL20 - Stutter brake opens above limit one and closes below it.
// RL21 - Motor short output switches an external short-circuit contactor.
// RL22 - Mains disconnect asserts whenever evacuation-active reports battery supply.
// RL23 - In evacuation, at standstill restart, then wait for line voltage.
// RL24 - The system sets evacuation-active whenever supply switches to battery.
// RL25 - Each contact is one clocked level, high meaning closed.
module drof_output_logic #(
  parameter NUM_OUT          = 4,
  parameter SPD_W            = 16,
  parameter FULL_LOAD_CYCLES = `DROF_FULL_LOAD_MS * `DROF_CLK_KHZ,
  parameter DIR_PULSE_CYCLES = `DROF_DIR_PULSE_MS * `DROF_CLK_KHZ
) (
  input  wire                       clk,
  input  wire                       sys_rst,
  input  wire [`DROF_ADDR_W-1:0]    avs_address,
  input  wire                       avs_read,
  input  wire                       avs_write,
  input  wire [31:0]                avs_writedata,
  input  wire [3:0]                 avs_byteenable,
  output reg  [31:0]                avs_readdata,
  output wire                       avs_waitrequest,
  input  wire [SPD_W-1:0]           actual_speed,
  input  wire [SPD_W-1:0]           nominal_speed,
  input  wire [SPD_W-1:0]           motor_current,
  input  wire                       closed_loop,
  input  wire                       constant_travel,
  input  wire                       decelerating,
  input  wire                       travel_speed_three,
  input  wire                       motor_energized,
  input  wire                       ctrl_enable,
  input  wire                       speed_select,
  input  wire                       dir_up,
  input  wire                       dir_down,
  input  wire                       mode_contactor_out,
  input  wire                       safe_torque_off,
  input  wire                       travelling,
  input  wire                       motor_short_req,
  input  wire                       life_tick,
  input  wire [3:0]                 brake_monitor_inputs,
  input  wire                       evac_active_input,
  input  wire                       line_voltage_ok,
  output reg  [NUM_OUT-1:0]         relay_out,
  output reg                        restart_req,
  output reg                        normal_op
);
  localparam NFN = 17;

  function [31:0] be_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  be;
    integer      k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        be_merge[k*8 +: 8] = be[k] ? new_v[k*8 +: 8] : old_v[k*8 +: 8];
      end
    end
  endfunction

  // Unknown codes fall through to open
  function pick_cond;
    input [`DROF_SEL_W-1:0] sel;
    input [NFN-1:0]         cond;
    begin
      if (sel == `DROF_FN_OFF || sel > `DROF_FN_LAST) begin
        pick_cond = 1'b0;                              // [RL2]
      end else begin
        pick_cond = cond[sel];                         // [RL1]
      end
    end
  endfunction

  // Register bus: one wait cycle per access, answer on the second
  reg                    ack_q;
  wire                   req = avs_read | avs_write;
  wire                   wr_en = avs_write & ack_q;
  // Old word for a write is the value captured in its wait cycle
  wire [31:0]            wr_merged = be_merge(avs_readdata, avs_writedata, avs_byteenable);
  reg [`DROF_SEL_W-1:0]  sel_q [0:NUM_OUT-1];
  reg [SPD_W-1:0]        limit1_q;
  reg [SPD_W-1:0]        limit2_q;
  reg [SPD_W-1:0]        curr_thr_q;
  reg [31:0]             flux_time_q;
  reg [7:0]              brake_cfg_q;
  reg [31:0]             life_load_q;
  reg [31:0]             life_warn_q;
  reg                    life_reload_q;
  reg [1:0]              ev_state_q;
  reg                    still_q;
  wire [31:0]            life_count;
  wire                   life_warn;
  integer                i;
  integer                j;

  assign avs_waitrequest = req & ~ack_q;

  always @(posedge clk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      for (i = 0; i < NUM_OUT; i = i + 1) begin
        sel_q[i] <= `DROF_RST_SEL;
      end
      limit1_q      <= `DROF_RST_SPEED;
      limit2_q      <= `DROF_RST_SPEED;
      curr_thr_q    <= `DROF_RST_SPEED;
      flux_time_q   <= `DROF_RST_FLUX;
      brake_cfg_q   <= `DROF_RST_BRK;
      life_load_q   <= `DROF_RST_LIFE;
      life_warn_q   <= `DROF_RST_LIFE;
      life_reload_q <= 1'b0;
    end else begin
      life_reload_q <= 1'b0;
      if (wr_en) begin
        case (avs_address)
          `DROF_REG_SEL0: begin
            if (avs_byteenable[0]) sel_q[0] <= avs_writedata[`DROF_SEL_W-1:0];
          end
          `DROF_REG_SEL1: begin
            if (avs_byteenable[0]) sel_q[1] <= avs_writedata[`DROF_SEL_W-1:0];
          end
          `DROF_REG_SEL2: begin
            if (avs_byteenable[0]) sel_q[2] <= avs_writedata[`DROF_SEL_W-1:0];
          end
          `DROF_REG_SEL3: begin
            if (avs_byteenable[0]) sel_q[3] <= avs_writedata[`DROF_SEL_W-1:0];
          end
          `DROF_REG_LIMIT1: begin
            limit1_q <= wr_merged[SPD_W-1:0];
          end
          `DROF_REG_LIMIT2: begin
            limit2_q <= wr_merged[SPD_W-1:0];
          end
          `DROF_REG_CURR_THR: begin
            curr_thr_q <= wr_merged[SPD_W-1:0];
          end
          `DROF_REG_FLUX_TIME: begin
            flux_time_q <= be_merge(flux_time_q, avs_writedata, avs_byteenable);
          end
          `DROF_REG_BRAKE_CFG: begin
            if (avs_byteenable[0]) brake_cfg_q <= avs_writedata[7:0];
          end
          `DROF_REG_LIFE_LOAD: begin
            life_load_q <= be_merge(life_load_q, avs_writedata, avs_byteenable);
          end
          `DROF_REG_LIFE_WARN: begin
            life_warn_q <= be_merge(life_warn_q, avs_writedata, avs_byteenable);
          end
          `DROF_REG_LIFE_CTRL: begin
            life_reload_q <= avs_byteenable[0] & avs_writedata[`DROF_LIFE_CTRL_RELOAD];
          end
          default: begin
          end
        endcase
      end
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (req && !ack_q) begin
      avs_readdata <= 32'h0000_0000;
      case (avs_address)
        `DROF_REG_SEL0:      avs_readdata[`DROF_SEL_W-1:0] <= sel_q[0];
        `DROF_REG_SEL1:      avs_readdata[`DROF_SEL_W-1:0] <= sel_q[1];
        `DROF_REG_SEL2:      avs_readdata[`DROF_SEL_W-1:0] <= sel_q[2];
        `DROF_REG_SEL3:      avs_readdata[`DROF_SEL_W-1:0] <= sel_q[3];
        `DROF_REG_LIMIT1:    avs_readdata[SPD_W-1:0] <= limit1_q;
        `DROF_REG_LIMIT2:    avs_readdata[SPD_W-1:0] <= limit2_q;
        `DROF_REG_CURR_THR:  avs_readdata[SPD_W-1:0] <= curr_thr_q;
        `DROF_REG_FLUX_TIME: avs_readdata <= flux_time_q;
        `DROF_REG_BRAKE_CFG: avs_readdata[7:0] <= brake_cfg_q;
        `DROF_REG_LIFE_LOAD: avs_readdata <= life_load_q;
        `DROF_REG_LIFE_WARN: avs_readdata <= life_warn_q;
        `DROF_REG_STATUS: begin
          avs_readdata[`DROF_ST_RELAY_LO +: 4]  <= relay_out[3:0];
          avs_readdata[`DROF_ST_EVAC_LO +: 2]   <= ev_state_q;
          avs_readdata[`DROF_ST_WARN]           <= life_warn;
          avs_readdata[`DROF_ST_STILL]          <= still_q;
        end
        `DROF_REG_LIFE_CNT:  avs_readdata <= life_count;
        default:             avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Brake monitor, evacuation-active and line voltage inputs pass two flops before use
  reg [5:0] pin_s1_q;
  reg [5:0] pin_s2_q;
  always @(posedge clk) begin
    if (sys_rst) begin
      pin_s1_q <= 6'h00;
      pin_s2_q <= 6'h00;
    end else begin
      pin_s1_q <= {line_voltage_ok, evac_active_input, brake_monitor_inputs};
      pin_s2_q <= pin_s1_q;
    end
  end
  wire [3:0] brake_sync = pin_s2_q[3:0];
  wire       evac_sync  = pin_s2_q[4];
  wire       line_sync  = pin_s2_q[5];

  // Speed comparisons
  wire [SPD_W-1:0] sel_speed   = closed_loop ? actual_speed : nominal_speed;
  wire             above_lim1  = actual_speed > limit1_q;
  wire             above_lim2  = actual_speed > limit2_q;
  wire             run_demand  = ctrl_enable & speed_select & (dir_up | dir_down);

  // Standstill holds its state between the two trip edges
  always @(posedge clk) begin
    if (sys_rst) begin
      still_q <= 1'b1;
    end else if (actual_speed != {SPD_W{1'b0}}) begin
      still_q <= 1'b0;                                 // [RL6]
    end else if (!mode_contactor_out) begin
      still_q <= 1'b1;                                 // [RL7]
    end
  end

  // Slowdown latch; zero speed clears and takes priority over a set
  reg sd_q;
  always @(posedge clk) begin
    if (sys_rst) begin
      sd_q <= 1'b0;
    end else if (sel_speed == {SPD_W{1'b0}}) begin
      sd_q <= 1'b0;                                    // [RL15]
    end else if (decelerating && travel_speed_three && sel_speed < limit1_q) begin
      sd_q <= 1'b1;                                    // [RL13] [RL14]
    end
  end

  // Direction change pulse; the last known direction survives stops
  reg [1:0]  last_dir_q;
  reg [31:0] pulse_cnt_q;
  wire [1:0] cur_dir = {dir_up & ~dir_down, dir_down & ~dir_up};
  wire       dir_change = (cur_dir != 2'b00) && (last_dir_q != 2'b00) &&
                          (cur_dir != last_dir_q);
  always @(posedge clk) begin
    if (sys_rst) begin
      last_dir_q  <= 2'b00;
      pulse_cnt_q <= 32'h0000_0000;
    end else begin
      if (cur_dir != 2'b00) begin
        last_dir_q <= cur_dir;
      end
      if (dir_change) begin
        pulse_cnt_q <= DIR_PULSE_CYCLES;               // [RL11]
      end else if (pulse_cnt_q != 32'h0000_0000) begin
        pulse_cnt_q <= pulse_cnt_q - 32'h0000_0001;
      end
    end
  end
  wire dir_pulse = pulse_cnt_q != 32'h0000_0000;

  // Brake open: every enabled monitor input at its open level
  wire [3:0] brk_mask = brake_cfg_q[`DROF_BRK_MASK_LO +: 4];
  wire [3:0] brk_pol  = brake_cfg_q[`DROF_BRK_POL_LO +: 4];
  wire [3:0] brk_open = (brake_sync ^ brk_pol) | ~brk_mask;
  wire       brakes_open = travelling & (|brk_mask) & (&brk_open);   // [RL18]

  wire flux_done;
  drof_hold_timer #(
    .W (32)
  ) u_flux (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (motor_energized),
    .limit   (flux_time_q),
    .done    (flux_done)
  );

  // Any dip below threshold restarts the 200 ms window
  wire full_load;
  drof_hold_timer #(
    .W (32)
  ) u_full (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (constant_travel & (motor_current > curr_thr_q)),  // [RL12]
    .limit   (FULL_LOAD_CYCLES),
    .done    (full_load)
  );

  drof_life_counter #(
    .W (32)
  ) u_life (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .reload   (life_reload_q),
    .load_val (life_load_q),
    .tick     (life_tick),
    .warn_thr (life_warn_q),
    .count    (life_count),
    .warn     (life_warn)
  );

  // Evacuation sequence
  reg [1:0] ev_state_d;
  always @* begin
    ev_state_d = ev_state_q;
    case (ev_state_q)
      `DROF_EV_IDLE: begin
        if (evac_sync) ev_state_d = `DROF_EV_WAIT_STILL;
      end
      `DROF_EV_WAIT_STILL: begin
        if (still_q) ev_state_d = `DROF_EV_RESTART;    // [RL23]
      end
      `DROF_EV_RESTART: begin
        ev_state_d = `DROF_EV_WAIT_LINE;
      end
      `DROF_EV_WAIT_LINE: begin
        if (line_sync && !evac_sync) ev_state_d = `DROF_EV_IDLE;   // [RL23]
      end
      default: begin
        ev_state_d = `DROF_EV_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      ev_state_q  <= `DROF_EV_IDLE;
      restart_req <= 1'b0;
      normal_op   <= 1'b0;
    end else begin
      ev_state_q  <= ev_state_d;
      restart_req <= (ev_state_d == `DROF_EV_RESTART);
      normal_op   <= (ev_state_d == `DROF_EV_IDLE);
    end
  end

  // Condition vector indexed by function code
  wire [NFN-1:0] cond;
  assign cond[0]  = 1'b0;
  assign cond[1]  = flux_done;                         // [RL3]
  assign cond[2]  = above_lim1;                        // [RL4]
  assign cond[3]  = above_lim2;                        // [RL5]
  assign cond[4]  = still_q;
  assign cond[5]  = ~run_demand & still_q;             // [RL8]
  assign cond[6]  = life_warn;
  assign cond[7]  = dir_pulse;
  assign cond[8]  = full_load;
  assign cond[9]  = sd_q;
  assign cond[10] = ~safe_torque_off;                  // [RL16]
  assign cond[11] = safe_torque_off;                   // [RL17]
  assign cond[12] = brakes_open;
  assign cond[13] = run_demand;                        // [RL19]
  assign cond[14] = ~above_lim1;                       // [RL20]
  assign cond[15] = motor_short_req;                   // [RL21]
  assign cond[16] = evac_sync;                         // [RL22]

  always @(posedge clk) begin
    if (sys_rst) begin
      relay_out <= {NUM_OUT{1'b0}};
    end else begin
      for (j = 0; j < NUM_OUT; j = j + 1) begin
        relay_out[j] <= pick_cond(sel_q[j], cond);     // [RL25]
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/drof_output_logic_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module drof_output_logic_monitor (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic [15:0] actual_speed,
  input wire logic        safe_torque_off,
  input wire logic        evac_active_input,
  input wire logic        ctrl_enable,
  input wire logic        speed_select,
  input wire logic        dir_up,
  input wire logic        dir_down,
  input wire logic [3:0]  relay_out,
  input wire logic        restart_req,
  input wire logic        normal_op
);
  logic [4:0]  s0_q;
  logic [15:0] lim1_q;
  // Shadows relay 0 selector and limit one; assumes full-word writes
  always @(posedge clk) begin
    if (sys_rst) begin
      s0_q <= 5'h00;
      lim1_q <= 16'h0000;
    end else if (avs_write && !avs_waitrequest) begin
      if (avs_address == 4'h0) s0_q <= avs_writedata[4:0];
      if (avs_address == 4'h4) lim1_q <= avs_writedata[15:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_off;
    s0_q == 5'h00 && $past(s0_q) == 5'h00 |-> !relay_out[0];
  endproperty
  a_off: assert property (p_off) else $error("relay 0 closed while off");
  property p_lim1;
    s0_q == 5'h02 && $past(s0_q) == 5'h02 |-> relay_out[0] == ($past(actual_speed) > $past(lim1_q));
  endproperty
  a_lim1: assert property (p_lim1) else $error("limit one relay wrong");
  property p_stut;
    s0_q == 5'h0E && $past(s0_q) == 5'h0E |-> relay_out[0] == ($past(actual_speed) <= $past(lim1_q));
  endproperty
  a_stut: assert property (p_stut) else $error("stutter relay wrong");
  property p_tq;
    s0_q == 5'h0A && $past(s0_q) == 5'h0A |-> relay_out[0] == !$past(safe_torque_off);
  endproperty
  a_tq: assert property (p_tq) else $error("torque status relay wrong");
  property p_ren;
    s0_q == 5'h0D && $past(s0_q) == 5'h0D
      |-> relay_out[0] == $past(ctrl_enable && speed_select && (dir_up || dir_down));
  endproperty
  a_ren: assert property (p_ren) else $error("regen enable relay wrong");
  property p_mains;
    s0_q == 5'h10 && $past(s0_q) == 5'h10 |-> relay_out[0] == $past(evac_active_input, 3);
  endproperty
  a_mains: assert property (p_mains) else $error("mains relay wrong");
  property p_rel;
    $fell(sys_rst) |-> relay_out == 4'h0;
  endproperty
  a_rel: assert property (p_rel) else $error("relay closed after reset");
  property p_rst;
    restart_req |=> !restart_req && !normal_op;
  endproperty
  a_rst: assert property (p_rst) else $error("restart pulse wrong");
endmodule
`default_nettype wire

// [testbench/drof_relay_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module drof_relay_partner (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] relay_out,
  output logic            brake_released,
  output logic [7:0]      pulse_count
);
  logic last_q;
  // Brake contactor on relay 0 acts at once, with no delay of its own
  assign brake_released = relay_out[0];
  // External counter counts closings of relay 0
  always @(posedge clk) begin
    last_q <= relay_out[0];
    if (sys_rst) pulse_count <= 8'h00;
    else if (relay_out[0] && !last_q) pulse_count <= pulse_count + 8'h01;
  end
endmodule
`default_nettype wire

// [testbench/drof_output_logic_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module drof_output_logic_tb;
  localparam logic [15:0] LIM1 = 16'h0100;
  logic        clk, sys_rst, avs_read, avs_write, avs_waitrequest, chk_q;
  logic [3:0]  avs_address, avs_byteenable, brake_monitor_inputs, relay_out;
  logic [31:0] avs_writedata, avs_readdata, r;
  logic [15:0] actual_speed, nominal_speed, motor_current;
  logic        closed_loop, constant_travel, decelerating, travel_speed_three, motor_energized;
  logic        ctrl_enable, speed_select, dir_up, dir_down, mode_contactor_out, safe_torque_off;
  logic        travelling, motor_short_req, life_tick, evac_active_input, line_voltage_ok;
  logic        restart_req, normal_op, brake_released;
  logic [7:0]  pulse_count, c0;
  logic [13:0] obs;
  logic [27:0] n;
  logic [31:0] rq[$];
  logic [27:0] oq[$];
  logic [4:0]  codes[13] = '{5'h00, 5'h02, 5'h03, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E,
                             5'h05, 5'h0F, 5'h10, 5'h11, 5'h1F};
  int          err_total, check_count, i, j;
  assign obs = {normal_op, pulse_count, brake_released, relay_out};
  drof_output_logic #(.FULL_LOAD_CYCLES(20), .DIR_PULSE_CYCLES(5)) dut (.*);
  drof_relay_partner prt (.*);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  always @(posedge clk) begin
    if (avs_read && !avs_waitrequest) cmp(avs_readdata, rq.pop_front());
    if (chk_q) begin
      n = oq.pop_front();
      cmp({18'h0, obs & n[27:14]}, {18'h0, n[13:0]});
    end
  end
  task automatic w(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic ex(input logic [13:0] mk, input logic [13:0] v);
    oq.push_back({mk, v & mk});
    chk_q <= 1'b1;
    w(1);
    chk_q <= 1'b0;
    w(1);
  endtask
  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic rd_n, input logic [3:0] a, input logic [15:0] d);
    w(1);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_read <= rd_n;
    avs_write <= !rd_n;
    do begin
      w(1);
    end while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus(1'b0, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] x);
    rq.push_back({16'h0000, x});
    bus(1'b1, a, 16'h0000);
  endtask
  function automatic logic fexp(input logic [4:0] c);
    case (c)
      5'h02: return actual_speed > LIM1;
      5'h03: return actual_speed > 16'h0200;
      5'h05: return !fexp(5'h0D) && actual_speed == 16'h0000;
      5'h0A: return !safe_torque_off;
      5'h0B: return safe_torque_off;
      5'h0C: return travelling && brake_monitor_inputs[0];
      5'h0D: return ctrl_enable && speed_select && (dir_up || dir_down);
      5'h0E: return actual_speed <= LIM1;
      5'h0F: return motor_short_req;
      5'h10: return evac_active_input;
      default: return 1'b0;
    endcase
  endfunction
  initial begin
    w(20000);
    cmp(32'h0, 32'h1);
    report_and_stop;
  end
  initial begin
    {sys_rst, avs_byteenable, line_voltage_ok} = 6'h3F;
    {avs_read, avs_write, avs_address, avs_writedata, chk_q, life_tick} = '0;
    {actual_speed, nominal_speed, motor_current, brake_monitor_inputs} = '0;
    {closed_loop, constant_travel, decelerating, travel_speed_three, motor_energized} = '0;
    {ctrl_enable, speed_select, dir_up, dir_down, mode_contactor_out, safe_torque_off} = '0;
    {travelling, motor_short_req, evac_active_input} = '0;
    void'($urandom(32'h7684));
    w(12);
    sys_rst <= 1'b0;
    ex(14'h000F, 14'h0000);
    rd(4'hE, 16'h0000);
    wr(4'h4, LIM1);
    wr(4'h5, 16'h0200);
    for (i = 0; i < 13; i++) begin
      wr(4'h0, {11'h000, codes[i]});
      rd(4'h0, {11'h000, codes[i]});
      for (j = 0; j < 4; j++) begin
        r = $urandom;
        actual_speed <= (j == 0) ? LIM1 : (j == 1) ? 16'h0000 : {6'h00, r[25:16]};
        {safe_torque_off, motor_short_req, evac_active_input, ctrl_enable} <= r[6:3];
        {speed_select, dir_up, travelling} <= r[2:0];
        dir_down <= r[7] & ~r[1];
        brake_monitor_inputs <= r[11:8];
        w(4);
        ex(14'h000F, {13'h0000, fexp(codes[i])});
      end
    end
    wr(4'h0, 16'h0004);
    wr(4'h1, 16'h0009);
    {closed_loop, travel_speed_three, mode_contactor_out, evac_active_input} <= 4'hE;
    actual_speed <= 16'h0300;
    w(3);
    decelerating <= 1'b1;
    actual_speed <= 16'h0050;
    w(3);
    ex(14'h0003, 14'h0002);
    actual_speed <= 16'h0000;
    w(3);
    ex(14'h0003, 14'h0000);
    mode_contactor_out <= 1'b0;
    w(3);
    ex(14'h0003, 14'h0001);
    closed_loop <= 1'b0;
    {nominal_speed, actual_speed} <= {16'h0300, 16'h0300};
    w(3);
    nominal_speed <= 16'h0080;
    w(3);
    ex(14'h0003, 14'h0002);
    nominal_speed <= 16'h0000;
    w(3);
    ex(14'h0002, 14'h0000);
    {decelerating, actual_speed} <= '0;
    wr(4'h1, 16'h0000);
    wr(4'h7, 16'h0010);
    wr(4'h0, 16'h0001);
    motor_energized <= 1'b1;
    w(8);
    ex(14'h001F, 14'h0000);
    w(14);
    ex(14'h001F, 14'h0011);
    motor_energized <= 1'b0;
    wr(4'h6, 16'h0100);
    wr(4'h0, 16'h0008);
    {constant_travel, motor_current} <= {1'b1, 16'h0200};
    w(10);
    motor_current <= 16'h0000;
    w(1);
    motor_current <= 16'h0200;
    w(16);
    ex(14'h000F, 14'h0000);
    w(8);
    ex(14'h000F, 14'h0001);
    constant_travel <= 1'b0;
    wr(4'h0, 16'h0007);
    {dir_up, dir_down} <= 2'b01;
    w(12);
    c0 = pulse_count;
    {dir_up, dir_down} <= 2'b10;
    w(12);
    {dir_up, dir_down} <= 2'b01;
    w(12);
    ex(14'h1FE0, {1'b0, c0 + 8'h02, 5'h00});
    wr(4'h0, 16'h0006);
    wr(4'h9, 16'h0003);
    wr(4'hA, 16'h0001);
    wr(4'hB, 16'h0001);
    w(2);
    ex(14'h000F, 14'h0000);
    for (i = 0; i < 3; i++) begin
      life_tick <= 1'b1;
      w(1);
      life_tick <= 1'b0;
      w(2);
      ex(14'h000F, {13'h0000, i > 0});
    end
    rd(4'hD, 16'h0000);
    wr(4'hB, 16'h0001);
    w(2);
    ex(14'h000F, 14'h0000);
    wr(4'h0, 16'h0010);
    {actual_speed, line_voltage_ok} <= {16'h0050, 1'b0};
    evac_active_input <= 1'b1;
    w(6);
    ex(14'h200F, 14'h0001);
    actual_speed <= 16'h0000;
    w(10);
    ex(14'h200F, 14'h0001);
    {evac_active_input, line_voltage_ok} <= 2'b01;
    w(8);
    ex(14'h200F, 14'h2000);
    report_and_stop;
  end
endmodule
bind drof_output_logic drof_output_logic_monitor mon (.*);
`default_nettype wire
